// ### rtl/avr_params.svh
// register map, function codes and limits of the measurement readout bank
`ifndef AVR_PARAMS_SVH
`define AVR_PARAMS_SVH
`define AVR_FC_READ_HOLD 8'h03
`define AVR_FC_READ_INPUT 8'h04
`define AVR_EXC_ILL_FUNC 8'h01
`define AVR_EXC_ILL_ADDR 8'h02
`define AVR_EXC_ILL_VALUE 8'h03
`define AVR_QTY_MIN 16'h0001
`define AVR_QTY_MAX 16'h007d
`define AVR_TC_FLT_LO 16'h03ea
`define AVR_TC_FLT_HI 16'h03eb
`define AVR_TF_FLT_LO 16'h03ec
`define AVR_TF_FLT_HI 16'h03ed
`define AVR_VM_FLT_LO 16'h0410
`define AVR_VM_FLT_HI 16'h0411
`define AVR_VF_FLT_LO 16'h0412
`define AVR_VF_FLT_HI 16'h0413
`define AVR_TC_INT 16'h0fa1
`define AVR_TF_INT 16'h0fa2
`define AVR_VM_INT 16'h0fb4
`define AVR_VF_INT 16'h0fb5
`define AVR_RESET_WORD 16'h0000
`endif

// ### rtl/avr_pkg.sv
// types shared by the measurement readout bank
`default_nettype none
package avr_pkg;
   typedef struct packed {
      logic [31:0] temp_celsius_float;
      logic [31:0] temp_fahrenheit_float;
      logic [31:0] velocity_mps_float;
      logic [31:0] velocity_ftmin_float;
      logic [15:0] temp_celsius_scaled;
      logic [15:0] temp_fahrenheit_scaled;
      logic [15:0] velocity_mps_scaled;
      logic [15:0] velocity_ftmin_scaled;
   } avr_meas_s;
   typedef struct packed {
      logic [7:0] func;
      logic [15:0] addr;
      logic [15:0] qty;
   } avr_req_s;
   typedef enum logic {ST_IDLE, ST_SEND} avr_state_e;
endpackage
`default_nettype wire

// ### rtl/avr_readout.sv
// read-only measurement register bank answering decoded read requests
// What this block does
// - function codes 0x03 and 0x04 both read every measurement, same contents.
// - float pairs at 0x3ea, 0x3ec, 0x410, 0x412 for degC, degF, m/s, ft/min.
// - scaled integers at 0xfa1, 0xfa2, 0xfb4, 0xfb5, one register each.
// - integers are value times 100, 50, 100 and 1 respectively.
// - request address equals one-based register number minus one.
// - floats are IEEE754 single precision: sign, 8 exponent, 23 mantissa bits.
// - lower address holds low mantissa half, higher one sign/exponent; high byte first.
// - metric/imperial choice fixed at manufacture, never changed afterwards.
// - both float halves come from one sample within one read.
`timescale 1ns/1ns
`default_nettype none
`include "avr_params.svh"
module avr_readout (
   input wire logic clk,
   input wire logic srst,
   input wire avr_pkg::avr_meas_s meas,
   input wire logic unit_imperial_strap,
   input wire logic req_valid,
   input wire avr_pkg::avr_req_s req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic rsp_last,
   output logic rsp_exc,
   output logic [7:0] rsp_exc_code,
   output logic unit_imperial
);
   avr_pkg::avr_state_e state_q, state_d;
   avr_pkg::avr_meas_s snap_q, snap_d;
   logic [15:0] addr_q, addr_d;
   logic [15:0] left_q, left_d;
   logic ready_q, ready_d;
   logic valid_q, valid_d;
   logic [15:0] data_q, data_d;
   logic last_q, last_d;
   logic exc_q, exc_d;
   logic [7:0] code_q, code_d;
   logic first_q, first_d;
   logic unit_q, unit_d;
   logic taken;
   logic func_ok;
   logic qty_ok;
   logic map_ok;
   logic [16:0] end_addr;

   // float pair: lower address low mantissa half, upper address sign and exponent
   function automatic logic [15:0] word_at(input logic [15:0] a, input avr_pkg::avr_meas_s m);
      logic [15:0] w;
      w = `AVR_RESET_WORD;
      case (a)
         `AVR_TC_FLT_LO: w = m.temp_celsius_float[15:0];
         `AVR_TC_FLT_HI: w = m.temp_celsius_float[31:16];
         `AVR_TF_FLT_LO: w = m.temp_fahrenheit_float[15:0];
         `AVR_TF_FLT_HI: w = m.temp_fahrenheit_float[31:16];
         `AVR_VM_FLT_LO: w = m.velocity_mps_float[15:0];
         `AVR_VM_FLT_HI: w = m.velocity_mps_float[31:16];
         `AVR_VF_FLT_LO: w = m.velocity_ftmin_float[15:0];
         `AVR_VF_FLT_HI: w = m.velocity_ftmin_float[31:16];
         `AVR_TC_INT: w = m.temp_celsius_scaled;
         `AVR_TF_INT: w = m.temp_fahrenheit_scaled;
         `AVR_VM_INT: w = m.velocity_mps_scaled;
         `AVR_VF_INT: w = m.velocity_ftmin_scaled;
         default: w = `AVR_RESET_WORD;
      endcase
      return w;
   endfunction

   // whole span must sit inside one mapped block; no partial answers
   always_comb
   begin
      taken = req_valid && ready_q;
      func_ok = (req.func == `AVR_FC_READ_HOLD) || (req.func == `AVR_FC_READ_INPUT);
      qty_ok = (req.qty >= `AVR_QTY_MIN) && (req.qty <= `AVR_QTY_MAX);
      end_addr = 17'({1'b0, req.addr} + {1'b0, req.qty} - 17'h1);
      map_ok = ((req.addr >= `AVR_TC_FLT_LO) && (end_addr <= {1'b0, `AVR_VF_FLT_HI})
                && (req.addr <= `AVR_TF_FLT_HI) && (end_addr <= {1'b0, `AVR_TF_FLT_HI}))
               || ((req.addr >= `AVR_VM_FLT_LO) && (end_addr <= {1'b0, `AVR_VF_FLT_HI}))
               || ((req.addr >= `AVR_TC_INT) && (end_addr <= {1'b0, `AVR_TF_INT}))
               || ((req.addr >= `AVR_VM_INT) && (end_addr <= {1'b0, `AVR_VF_INT}));
   end

   always_comb
   begin
      state_d = state_q;
      snap_d = snap_q;
      addr_d = addr_q;
      left_d = left_q;
      ready_d = ready_q;
      valid_d = 1'b0;
      data_d = data_q;
      last_d = 1'b0;
      exc_d = 1'b0;
      code_d = code_q;
      unique case (state_q)
         avr_pkg::ST_IDLE:
         begin
            ready_d = 1'b1;
            if (taken)
            begin
               if (!func_ok)
               begin
                  exc_d = 1'b1;
                  code_d = `AVR_EXC_ILL_FUNC;
               end
               else if (!qty_ok)
               begin
                  exc_d = 1'b1;
                  code_d = `AVR_EXC_ILL_VALUE;
               end
               else if (!map_ok)
               begin
                  exc_d = 1'b1;
                  code_d = `AVR_EXC_ILL_ADDR;
               end
               else
               begin
                  // one snapshot per request keeps float halves coherent
                  snap_d = meas;
                  addr_d = req.addr;
                  left_d = req.qty;
                  ready_d = 1'b0;
                  state_d = avr_pkg::ST_SEND;
               end
            end
         end
         avr_pkg::ST_SEND:
         begin
            valid_d = 1'b1;
            data_d = word_at(addr_q, snap_q);
            addr_d = 16'(addr_q + 16'h1);
            left_d = 16'(left_q - 16'h1);
            if (left_q == `AVR_QTY_MIN)
            begin
               last_d = 1'b1;
               ready_d = 1'b1;
               state_d = avr_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_q <= avr_pkg::ST_IDLE;
         snap_q <= '0;
         addr_q <= `AVR_RESET_WORD;
         left_q <= `AVR_RESET_WORD;
         ready_q <= 1'b0;
         valid_q <= 1'b0;
         data_q <= `AVR_RESET_WORD;
         last_q <= 1'b0;
         exc_q <= 1'b0;
         code_q <= 8'h00;
      end
      else
      begin
         state_q <= state_d;
         snap_q <= snap_d;
         addr_q <= addr_d;
         left_q <= left_d;
         ready_q <= ready_d;
         valid_q <= valid_d;
         data_q <= data_d;
         last_q <= last_d;
         exc_q <= exc_d;
         code_q <= code_d;
      end
   end

   // unit choice caught once after reset release; later strap changes are ignored
   always_comb
   begin
      first_d = 1'b0;
      unit_d = first_q ? unit_imperial_strap : unit_q;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         first_q <= 1'b1;
         unit_q <= 1'b0;
      end
      else
      begin
         first_q <= first_d;
         unit_q <= unit_d;
      end
   end

   assign req_ready = ready_q;
   assign rsp_valid = valid_q;
   assign rsp_data = data_q;
   assign rsp_last = last_q;
   assign rsp_exc = exc_q;
   assign rsp_exc_code = code_q;
   assign unit_imperial = unit_q;

   property p_read_fc_ok;
      @(posedge clk) disable iff (srst)
      taken && func_ok && qty_ok && map_ok |-> ##2 rsp_valid && !rsp_exc;
   endproperty
   a_read_fc_ok: assert property (p_read_fc_ok) else $error("read request not served");

   property p_bad_func;
      @(posedge clk) disable iff (srst)
      taken && !func_ok |=> rsp_exc && rsp_exc_code == `AVR_EXC_ILL_FUNC && !rsp_valid;
   endproperty
   a_bad_func: assert property (p_bad_func) else $error("bad function not refused");

   property p_bad_addr;
      @(posedge clk) disable iff (srst)
      taken && func_ok && qty_ok && !map_ok |=> rsp_exc && rsp_exc_code == `AVR_EXC_ILL_ADDR;
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("unmapped address not refused");

   property p_float_lo;
      @(posedge clk) disable iff (srst)
      state_q == avr_pkg::ST_SEND && addr_q == `AVR_TC_FLT_LO
         |=> rsp_valid && rsp_data == snap_q.temp_celsius_float[15:0];
   endproperty
   a_float_lo: assert property (p_float_lo) else $error("float low half wrong");

   property p_float_hi;
      @(posedge clk) disable iff (srst)
      state_q == avr_pkg::ST_SEND && addr_q == `AVR_VM_FLT_HI
         |=> rsp_data == snap_q.velocity_mps_float[31:16];
   endproperty
   a_float_hi: assert property (p_float_hi) else $error("float high half wrong");

   property p_scaled;
      @(posedge clk) disable iff (srst)
      state_q == avr_pkg::ST_SEND && addr_q == `AVR_VF_INT
         |=> rsp_data == snap_q.velocity_ftmin_scaled;
   endproperty
   a_scaled: assert property (p_scaled) else $error("scaled word wrong");

   property p_start_addr;
      @(posedge clk) disable iff (srst)
      taken && func_ok && qty_ok && map_ok |=> addr_q == $past(req.addr);
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("start address not kept");

   property p_snap_stable;
      @(posedge clk) disable iff (srst)
      state_q == avr_pkg::ST_SEND |=> $stable(snap_q);
   endproperty
   a_snap_stable: assert property (p_snap_stable) else $error("snapshot moved in read");

   property p_unit_fixed;
      @(posedge clk) disable iff (srst)
      !first_q |=> $stable(unit_imperial);
   endproperty
   a_unit_fixed: assert property (p_unit_fixed) else $error("unit selection changed");

   c_float_pair: cover property (@(posedge clk) disable iff (srst)
      taken && req.addr == `AVR_TC_FLT_LO && req.qty == 16'h0002 ##3 rsp_last);
   c_input_fc: cover property (@(posedge clk) disable iff (srst)
      taken && req.func == `AVR_FC_READ_INPUT && map_ok);
   c_exception: cover property (@(posedge clk) disable iff (srst)
      rsp_exc && rsp_exc_code == `AVR_EXC_ILL_ADDR);
endmodule
`default_nettype wire

// ### tb/avr_master.sv
// bus master model that issues one read request at a time to the readout bank
`timescale 1ns/1ns
`default_nettype none
module avr_master (
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   input wire avr_pkg::avr_req_s cmd,
   input wire logic req_ready,
   input wire logic rsp_last,
   input wire logic rsp_exc,
   output var logic req_valid,
   output var avr_pkg::avr_req_s req,
   output var logic busy
);
   // whole span in one request: first address and count together
   always @(posedge clk)
      if (srst)
      begin
         req_valid <= 1'b0;
         req <= '0;
         busy <= 1'b0;
      end
      else if (start)
      begin
         req_valid <= 1'b1;
         req <= cmd;
         busy <= 1'b1;
      end
      else
      begin
         // released lines show an inverted stale value, so a late sample cannot pass
         if (req_valid && req_ready)
         begin
            req_valid <= 1'b0;
            req <= ~req;
         end
         if (busy && !req_valid && (rsp_last || rsp_exc))
            busy <= 1'b0;
      end
endmodule
`default_nettype wire

// ### tb/avr_readout_tb_top.sv
// self-checking bench for the measurement readout bank
`timescale 1ns/1ns
`default_nettype none
module avr_readout_tb_top;
   typedef struct packed {
      logic [7:0] func;
      logic [15:0] addr;
      logic [15:0] qty;
      logic [7:0] code;
      logic [63:0] w;
   } avr_row_s;
   localparam logic [31:0] tcf = 32'h41d5385f;
   localparam logic [31:0] tff = 32'h429ff0a4;
   localparam logic [31:0] vmf = 32'h40b00000;
   localparam logic [31:0] vff = 32'h44876000;
   localparam logic [15:0] tcs = 16'h0a69;
   localparam logic [15:0] tfs = 16'h0f9e;
   localparam logic [15:0] vms = 16'h0226;
   localparam logic [15:0] vfs = 16'h043b;
   logic clk, srst, start, strap, req_valid, req_ready, rsp_valid, rsp_last, rsp_exc;
   logic unit_imperial, busy;
   logic [15:0] rsp_data, last_at;
   logic [7:0] rsp_exc_code, exc_seen;
   avr_pkg::avr_req_s cmd, req;
   avr_pkg::avr_meas_s meas;
   logic [15:0] got [$];
   int mismatches = 0;
   int checks_done = 0;
   avr_row_s rows [12] = '{
      {8'h03, 16'h03ea, 16'h0002, 8'h00, tcf[15:0], tcf[31:16], 32'h0},
      {8'h04, 16'h03ea, 16'h0002, 8'h00, tcf[15:0], tcf[31:16], 32'h0},
      {8'h04, 16'h03ec, 16'h0002, 8'h00, tff[15:0], tff[31:16], 32'h0},
      {8'h03, 16'h0410, 16'h0004, 8'h00, vmf[15:0], vmf[31:16], vff[15:0], vff[31:16]},
      {8'h04, 16'h03eb, 16'h0001, 8'h00, tcf[31:16], 48'h0},
      {8'h03, 16'h0fa1, 16'h0002, 8'h00, tcs, tfs, 32'h0},
      {8'h04, 16'h0fb4, 16'h0002, 8'h00, vms, vfs, 32'h0},
      {8'h03, 16'h03e9, 16'h0001, 8'h02, 64'h0},
      {8'h05, 16'h03ea, 16'h0002, 8'h01, 64'h0},
      {8'h03, 16'h03ea, 16'h0000, 8'h03, 64'h0},
      {8'h04, 16'h0fa2, 16'h0002, 8'h02, 64'h0},
      {8'h03, 16'h0412, 16'h0003, 8'h02, 64'h0}};

   avr_readout uut (.clk(clk), .srst(srst), .meas(meas), .unit_imperial_strap(strap),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_exc(rsp_exc),
      .rsp_exc_code(rsp_exc_code), .unit_imperial(unit_imperial));
   avr_master master (.clk(clk), .srst(srst), .start(start), .cmd(cmd), .req_ready(req_ready),
      .rsp_last(rsp_last), .rsp_exc(rsp_exc), .req_valid(req_valid), .req(req), .busy(busy));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (rsp_valid) got.push_back(rsp_data);
      if (rsp_valid && rsp_last) last_at = 16'(got.size());
      if (rsp_exc) exc_seen = rsp_exc_code;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic send(input avr_pkg::avr_req_s c);
      got.delete();
      exc_seen = 8'h00;
      last_at = 16'h0000;
      cmd <= c;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask
   task automatic finish_req;
      int n;
      n = 0;
      @(posedge clk);
      while (busy && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      chk("busy timeout", 16'h0000, {15'h0, busy});
   endtask
   task automatic check_row(input avr_row_s r);
      chk("words", (r.code == 8'h00) ? r.qty : 16'h0000, 16'(got.size()));
      chk("exc code", {8'h00, r.code}, {8'h00, exc_seen});
      if (r.code == 8'h00)
      begin
         chk("last pos", r.qty, last_at);
         for (int i = 0; i < r.qty && i < got.size(); i++)
            chk("word", r.w[63 - 16 * i -: 16], got[i]);
      end
   endtask
   task automatic test_done;
      if (mismatches == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge clk);
      mismatches++;
      test_done();
   end
   initial
   begin
      srst = 1'b1;
      start = 1'b0;
      cmd = '0;
      strap = 1'b1;
      meas = {tcf, tff, vmf, vff, tcs, tfs, vms, vfs};
      repeat (5) @(posedge clk);
      chk("ready in reset", 16'h0000, {15'h0, req_ready});
      srst <= 1'b0;
      repeat (3) @(posedge clk);
      chk("unit", 16'h0001, {15'h0, unit_imperial});
      strap <= 1'b0;
      foreach (rows[i])
      begin
         send({rows[i].func, rows[i].addr, rows[i].qty});
         finish_req();
         check_row(rows[i]);
      end
      chk("unit held", 16'h0001, {15'h0, unit_imperial});
      chk("ready idle", 16'h0001, {15'h0, req_ready});
      // live values change right at the take edge; the answer must keep the old sample
      send({8'h03, 16'h03ea, 16'h0004});
      for (int k = 0; k < 5 && !(req_valid && req_ready); k++) @(posedge clk);
      meas <= ~meas;
      finish_req();
      check_row({8'h03, 16'h03ea, 16'h0004, 8'h00, tcf[15:0], tcf[31:16], tff[15:0],
         tff[31:16]});
      test_done();
   end
endmodule
`default_nettype wire
